// file: design/wwd_pkg.sv
// shared constants and types of the windowed watchdog
package wwd_pkg;

    // register byte addresses
    localparam logic [31:0] WWD_ADDR_CTRL   = 32'h4000_2c00;
    localparam logic [31:0] WWD_ADDR_CFG    = 32'h4000_2c04;
    localparam logic [31:0] WWD_ADDR_STAT   = 32'h4000_2c08;

    // field positions
    localparam int          WWD_ARM_BIT     = 7;
    localparam int          WWD_MSB_BIT     = 6;
    localparam int          WWD_EWI_BIT     = 9;
    localparam int          WWD_TB_LSB      = 7;
    localparam int          WWD_FLAG_BIT    = 0;

    // widths
    localparam int          WWD_CNT_W       = 7;
    localparam int          WWD_DIV_W       = 15;

    // counter landmarks
    localparam logic [6:0]  WWD_EARLY_VAL   = 7'h40;
    localparam logic [6:0]  WWD_PRE_EARLY   = 7'h41;
    localparam logic [6:0]  WWD_WRAP_VAL    = 7'h7f;

    // values after reset
    localparam logic [6:0]  WWD_CNT_RST     = 7'h7f;
    localparam logic [6:0]  WWD_WIN_RST     = 7'h7f;
    localparam logic [1:0]  WWD_TB_RST      = 2'h0;

    // base division of the bus clock, in cycles
    localparam int unsigned WWD_BASE_DIV    = 4096;

    // register bus request, sampled on the bus clock
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [15:0] wdata;
    } wwd_bus_req_t;

    // tick divider state
    typedef struct packed {
        logic [WWD_DIV_W-1:0] cnt;
        logic                 tick;
    } wwd_div_state_t;

    localparam wwd_div_state_t WWD_DIV_RST = '{cnt: 15'h0000, tick: 1'b0};

    // watchdog core state
    typedef struct packed {
        logic                 armed;
        logic [WWD_CNT_W-1:0] counter;
        logic [WWD_CNT_W-1:0] window;
        logic [1:0]           tb_sel;
        logic                 ewi_en;
        logic                 ew_flag;
        logic                 rst_req;
        logic                 irq;
        logic [15:0]          rdata;
    } wwd_state_t;

    localparam wwd_state_t WWD_STATE_RST = '{
        armed: 1'b0, counter: WWD_CNT_RST, window: WWD_WIN_RST, tb_sel: WWD_TB_RST,
        ewi_en: 1'b0, ew_flag: 1'b0, rst_req: 1'b0, irq: 1'b0, rdata: 16'h0000};

endpackage : wwd_pkg

// file: design/wwd_tick_div.sv
// tick divider: bus clock / base / 2^select
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_div #(
    parameter int unsigned BASE_DIV = wwd_pkg::WWD_BASE_DIV
) (
    input  wire logic       ref_clk_in,   // bus clock
    input  wire logic       nrst_in,      // async reset, active low
    input  wire logic       clr_in,       // sync module reset
    input  wire logic       en_in,        // count enable
    input  wire logic [1:0] tb_sel_in,    // timebase select
    output logic            tick_out      // one-cycle tick pulse
);
    import wwd_pkg::*;

    wwd_div_state_t state;
    wwd_div_state_t next_state;
    logic [WWD_DIV_W-1:0] term;

    // last count of a period; >= catches a select that shrank mid-period
    function automatic logic [WWD_DIV_W-1:0] wwd_term(input logic [1:0] sel);
        logic [WWD_DIV_W:0] full;
        full = (WWD_DIV_W+1)'(BASE_DIV) << sel;
        return WWD_DIV_W'(full - 1'b1);
    endfunction

    assign term = wwd_term(tb_sel_in);

    // next-state of the divider
    always_comb begin
        next_state      = state;
        next_state.tick = 1'b0;
        if (clr_in) begin
            next_state = WWD_DIV_RST;
        end else if (en_in) begin                               // R14
            if (state.cnt >= term) begin                        // R2
                next_state.cnt  = '0;
                next_state.tick = 1'b1;
            end else begin
                next_state.cnt = state.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= WWD_DIV_RST;
        end else begin
            state <= next_state;
        end
    end

    assign tick_out = state.tick;

    property p_tick_cnt;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        tick_out |-> $past(state.cnt) >= $past(term) && $past(en_in) && state.cnt == '0;
    endproperty
    a_tick_cnt: assert property (p_tick_cnt) else $error("tick without full period"); // R2

endmodule : wwd_tick_div
`default_nettype wire

// file: design/wwd_top.sv
// windowed watchdog: counter, window compare, early warning, reset request
// How it works
// R1: the 7-bit counter counts down and wraps on every tick, armed or not.
// R2: one tick comes every base times 2^select bus clocks (select 0..3 gives 1,2,4,8).
// R3: arming is off after reset, a written 1 arms, a 0 does nothing, only reset disarms.
// R4: when armed, a tick taking the counter from 0x40 to 0x3f requests a system reset.
// R5: when armed, a counter write with the top bit 0 requests a system reset.
// R6: when armed, a counter write while the counter is above the window requests a reset.
// R7: software refreshes while the counter is at or below the window value, which reloads with no reset.
// R8: the window holds what software wrote, is only compared, and resets to all ones.
// R9: the early-warning flag sets when the counter steps to 0x40, enable or not.
// R10: with the warning enable set, the interrupt rises together with the flag.
// R11: the warning enable is set by a written 1, ignores 0, and clears only on reset.
// R12: one tick lies between the warning and the timeout, the window for a last refresh.
// R13: in debug halt the counter runs on or freezes as the debug input selects.
// R14: dropping the clock enable stops the count, and the module reset restores all state.
// R15: the warning flag clears only on a written 0 or a reset; a written 1 is ignored.
// R16: reserved bits read zero and ignore writes; the counter field reads live.
// R17: the reset request is a one-cycle pulse, raised only while armed.
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
    parameter int unsigned BASE_DIV = wwd_pkg::WWD_BASE_DIV
) (
    input  wire logic                 ref_clk_in,      // bus clock, 40 MHz
    input  wire logic                 nrst_in,         // async reset, active low
    input  wire logic                 clk_en_in,       // module clock enable
    input  wire logic                 mod_rst_in,      // sync module reset, active high
    input  wire logic                 dbg_halt_in,     // core halted in debug
    input  wire logic                 dbg_freeze_in,   // freeze counter while halted
    input  wire wwd_pkg::wwd_bus_req_t bus_req_in,     // register access
    output logic [15:0]               rdata_out,       // read data, one cycle after rd
    output logic                      sys_rst_req_out, // system reset request pulse
    output logic                      irq_out          // watchdog interrupt level
);
    import wwd_pkg::*;

    wwd_state_t state;
    wwd_state_t next_state;

    logic div_en;
    logic tick_raw;
    logic tick;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_stat;
    logic arm_now;
    logic wr_bad;
    logic cause;

    // freeze in debug only when asked; no enable, no counting
    assign div_en = clk_en_in && !(dbg_halt_in && dbg_freeze_in);  // R13 R14

    wwd_tick_div #(
        .BASE_DIV (BASE_DIV)
    ) u_div (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .clr_in     (mod_rst_in),
        .en_in      (div_en),
        .tb_sel_in  (state.tb_sel),
        .tick_out   (tick_raw)
    );

    // a tick already in flight when the halt begins is dropped too
    assign tick = tick_raw && div_en;

    // address decode
    assign wr_ctrl = bus_req_in.wr && (bus_req_in.addr == WWD_ADDR_CTRL);
    assign wr_cfg  = bus_req_in.wr && (bus_req_in.addr == WWD_ADDR_CFG);
    assign wr_stat = bus_req_in.wr && (bus_req_in.addr == WWD_ADDR_STAT);

    // the write's own arm bit counts, so arm plus bad value resets at once
    assign arm_now = state.armed || bus_req_in.wdata[WWD_ARM_BIT];
    assign wr_bad  = arm_now && (!bus_req_in.wdata[WWD_MSB_BIT]        // R5
                                 || (state.counter > state.window));   // R6

    // read mux, reserved bits zero
    function automatic logic [15:0] wwd_read(input wwd_state_t s, input logic [31:0] a);
        logic [15:0] d;
        d = 16'h0000;
        case (a)
            WWD_ADDR_CTRL: begin
                d[WWD_ARM_BIT]            = s.armed;
                d[WWD_CNT_W-1:0]          = s.counter;
            end
            WWD_ADDR_CFG: begin
                d[WWD_EWI_BIT]            = s.ewi_en;
                d[WWD_TB_LSB +: 2]        = s.tb_sel;
                d[WWD_CNT_W-1:0]          = s.window;
            end
            WWD_ADDR_STAT: begin
                d[WWD_FLAG_BIT]           = s.ew_flag;
            end
            default: begin
                d = 16'h0000;
            end
        endcase
        return d;
    endfunction

    // next state of the whole block
    always_comb begin
        next_state         = state;
        next_state.rst_req = 1'b0;
        cause              = 1'b0;
        if (mod_rst_in) begin
            next_state = WWD_STATE_RST;                                  // R14
        end else begin
            // flag clear first so a same-cycle set below wins
            if (wr_stat && !bus_req_in.wdata[WWD_FLAG_BIT]) begin
                next_state.ew_flag = 1'b0;                               // R15
            end
            // free-running count, wraps 0 -> 7f through plain subtraction
            if (tick) begin
                next_state.counter = state.counter - 1'b1;               // R1
                if (state.counter == WWD_PRE_EARLY) begin
                    next_state.ew_flag = 1'b1;                           // R9
                end
                if (state.counter == WWD_EARLY_VAL) begin
                    cause = state.armed;                                 // R4 R12
                end
            end
            // refresh overrides the tick, so a feed in the last tick saves it
            if (wr_ctrl) begin
                next_state.counter = bus_req_in.wdata[WWD_CNT_W-1:0];   // R7
                next_state.armed   = arm_now;                            // R3
                cause              = wr_bad;                             // R5 R6
            end
            // configuration; window is touched by nothing else
            if (wr_cfg) begin
                next_state.window = bus_req_in.wdata[WWD_CNT_W-1:0];    // R8
                next_state.tb_sel = bus_req_in.wdata[WWD_TB_LSB +: 2];   // R2
                next_state.ewi_en = state.ewi_en
                                    || bus_req_in.wdata[WWD_EWI_BIT];    // R11
            end
            // back-to-back causes would merge; the controller needs one edge
            next_state.rst_req = cause && !state.rst_req;                // R17
            next_state.irq     = next_state.ew_flag && next_state.ewi_en; // R10
            if (bus_req_in.rd) begin
                next_state.rdata = wwd_read(state, bus_req_in.addr);     // R16
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= WWD_STATE_RST;
        end else begin
            state <= next_state;
        end
    end

    assign rdata_out       = state.rdata;
    assign sys_rst_req_out = state.rst_req;
    assign irq_out         = state.irq;

    // checks, all on the bus clock
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    property p_wrap;
        tick && !mod_rst_in && !wr_ctrl && state.counter == 7'h00
        |=> state.counter == WWD_WRAP_VAL;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // R1

    property p_step;
        tick && !mod_rst_in && !wr_ctrl |=> state.counter == $past(state.counter) - 7'h01;
    endproperty
    a_step: assert property (p_step) else $error("counter did not step"); // R1

    property p_arm_sticky;
        state.armed && !mod_rst_in |=> state.armed;
    endproperty
    a_arm_sticky: assert property (p_arm_sticky) else $error("arm bit dropped"); // R3

    property p_timeout;
        tick && !mod_rst_in && !wr_ctrl && state.armed && !state.rst_req
        && state.counter == WWD_EARLY_VAL
        |=> sys_rst_req_out && state.counter == 7'h3f;
    endproperty
    a_timeout: assert property (p_timeout) else $error("missed timeout reset"); // R4

    property p_sw_reset;
        wr_ctrl && !mod_rst_in && arm_now && !state.rst_req
        && !bus_req_in.wdata[WWD_MSB_BIT] |=> sys_rst_req_out;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("missed software reset"); // R5

    property p_early_feed;
        wr_ctrl && !mod_rst_in && state.armed && !state.rst_req
        && state.counter > state.window |=> sys_rst_req_out;
    endproperty
    a_early_feed: assert property (p_early_feed) else $error("missed early feed reset"); // R6

    property p_window_hold;
        !wr_cfg && !mod_rst_in |=> $stable(state.window);
    endproperty
    a_window_hold: assert property (p_window_hold) else $error("window changed"); // R8

    property p_early_flag;
        tick && !mod_rst_in && !wr_ctrl && state.counter == WWD_PRE_EARLY
        |=> state.ew_flag && state.counter == WWD_EARLY_VAL;
    endproperty
    a_early_flag: assert property (p_early_flag) else $error("warning flag not set"); // R9

    property p_irq_with_flag;
        $rose(state.ew_flag) && state.ewi_en |-> irq_out;
    endproperty
    a_irq_with_flag: assert property (p_irq_with_flag) else $error("interrupt late"); // R10

    property p_ewi_sticky;
        state.ewi_en && !mod_rst_in |=> state.ewi_en;
    endproperty
    a_ewi_sticky: assert property (p_ewi_sticky) else $error("warning enable dropped"); // R11

    property p_freeze;
        dbg_halt_in && dbg_freeze_in && !wr_ctrl && !mod_rst_in |=> $stable(state.counter);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter ran in frozen halt"); // R13

    property p_mod_rst;
        mod_rst_in |=> !state.armed && state.counter == WWD_CNT_RST && !state.ew_flag
                       && !sys_rst_req_out;
    endproperty
    a_mod_rst: assert property (p_mod_rst) else $error("module reset incomplete"); // R14

    property p_flag_hold;
        state.ew_flag && !mod_rst_in && !(wr_stat && !bus_req_in.wdata[WWD_FLAG_BIT])
        |=> state.ew_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("warning flag lost"); // R15

    property p_read_ctrl;
        bus_req_in.rd && !mod_rst_in && bus_req_in.addr == WWD_ADDR_CTRL
        |=> rdata_out == {8'h00, $past(state.armed), $past(state.counter)};
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong"); // R16

    property p_rst_pulse;
        sys_rst_req_out |-> state.armed ##1 !sys_rst_req_out;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request malformed"); // R17

endmodule : wwd_top
`default_nettype wire

// file: tb/wwd_top_tb_top.sv
// self-checking testbench of the windowed watchdog top
`timescale 1ns/1ps
`default_nettype none
module wwd_top_tb_top;
    import wwd_pkg::*;

    // short base division keeps the run brief
    localparam int unsigned BASE = 4;

    logic         ref_clk_in    = 1'b0;
    logic         nrst_in       = 1'b0;
    logic         clk_en_in     = 1'b0;
    logic         mod_rst_in    = 1'b0;
    logic         dbg_halt_in   = 1'b0;
    logic         dbg_freeze_in = 1'b0;
    wwd_bus_req_t bus_req_in    = '0;
    logic [15:0]  rdata_out;
    logic         sys_rst_req_out;
    logic         irq_out;
    int           num_errors    = 0;
    int           n_checks      = 0;
    int           cyc           = 0;
    int           t0;
    int           t1;
    int           i;
    logic [15:0]  q;
    logic [15:0]  q2;
    logic         p;

    wwd_top #(.BASE_DIV(BASE)) u_wwd_top (
        .ref_clk_in      (ref_clk_in),
        .nrst_in         (nrst_in),
        .clk_en_in       (clk_en_in),
        .mod_rst_in      (mod_rst_in),
        .dbg_halt_in     (dbg_halt_in),
        .dbg_freeze_in   (dbg_freeze_in),
        .bus_req_in      (bus_req_in),
        .rdata_out       (rdata_out),
        .sys_rst_req_out (sys_rst_req_out),
        .irq_out         (irq_out)
    );

    // 40 MHz bus clock
    always #12.5 ref_clk_in = ~ref_clk_in;

    // cycle count, and a ceiling well above the expected run of under a thousand
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one access, entered just after an edge; p is the pulse seen, q the read data
    task acc(input logic w, input logic [31:0] a, input logic [15:0] d);
        bus_req_in <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk_in);
        bus_req_in.wr <= 1'b0;
        bus_req_in.rd <= 1'b0;
        #1 p = sys_rst_req_out;
        @(posedge ref_clk_in);
        #1 q = rdata_out;
    endtask

    task wr(input logic [31:0] a, input logic [15:0] d);
        acc(1'b1, a, d);
    endtask

    task rd(input logic [31:0] a);
        acc(1'b0, a, 16'h0000);
    endtask

    // measure one full tick period at a select; polling every 2 cycles is exact for even periods
    task per(input int s);
        int j;
        int n;
        wr(WWD_ADDR_CFG, 16'(s << 7) | 16'h0050);
        rd(WWD_ADDR_CTRL);
        q2 = q;
        n = 0;
        for (j = 0; j < 100 && n < 3; j++) begin
            rd(WWD_ADDR_CTRL);
            if (q !== q2) begin
                n++;
                if (n == 2) t0 = cyc;
                if (n == 3) t1 = cyc;
            end
            q2 = q;
        end
        chk(16'(t1 - t0), 16'(BASE << s));
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        wait_cyc(1);
        rd(WWD_ADDR_CTRL);  chk(q, 16'h007f);
        rd(WWD_ADDR_CFG);   chk(q, 16'h007f);
        rd(WWD_ADDR_STAT);  chk(q, 16'h0000);
        wr(32'h4000_2c0c, 16'hffff);
        rd(32'h4000_2c0c);  chk(q, 16'h0000);
        wr(WWD_ADDR_CFG, 16'hfc50);
        rd(WWD_ADDR_CFG);   chk(q, 16'h0050);
        clk_en_in <= 1'b1;
        wr(WWD_ADDR_CTRL, 16'h0030); chk(p, 1'b0);
        for (int s = 0; s < 4; s++) per(s);
        // arm, then let the count run into the warning and the timeout
        wr(WWD_ADDR_CFG, 16'h007f);
        wr(WWD_ADDR_CTRL, 16'h00ff); chk(p, 1'b0);
        wr(WWD_ADDR_STAT, 16'h0000);
        wr(WWD_ADDR_CFG, 16'h027f);  chk(irq_out, 1'b0);
        for (i = 0; i < 400 && irq_out !== 1'b1; i++) wait_cyc(1);
        chk(irq_out, 1'b1);
        t0 = cyc;
        chk(sys_rst_req_out, 1'b0);
        rd(WWD_ADDR_STAT);  chk(q, 16'h0001);
        for (i = 0; i < 20 && sys_rst_req_out !== 1'b1; i++) wait_cyc(1);
        t1 = cyc;
        chk(16'(t1 - t0), 16'(BASE));
        wait_cyc(1);        chk(sys_rst_req_out, 1'b0);
        rd(WWD_ADDR_CTRL);  chk(q, 16'h00bf);
        // of the two writes, only a written 0 clears the flag
        wr(WWD_ADDR_STAT, 16'h0001);
        rd(WWD_ADDR_STAT);  chk(q, 16'h0001);
        wr(WWD_ADDR_STAT, 16'h0000);
        rd(WWD_ADDR_STAT);  chk(q, 16'h0000);
        chk(irq_out, 1'b0);
        wr(WWD_ADDR_CFG, 16'h0050);
        rd(WWD_ADDR_CFG);   chk(q, 16'h0250);
        // disarm attempt, then refresh above the window
        wr(WWD_ADDR_CTRL, 16'h0070); chk(p, 1'b0);
        rd(WWD_ADDR_CTRL);  chk(q & 16'h0080, 16'h0080);
        wr(WWD_ADDR_CTRL, 16'h0070); chk(p, 1'b1);
        for (i = 0; i < 200; i++) begin
            rd(WWD_ADDR_CTRL);
            if (q[6:0] < 7'h4f) break;
        end
        wr(WWD_ADDR_CTRL, 16'h0048); chk(p, 1'b0);
        wr(WWD_ADDR_CTRL, 16'h0030); chk(p, 1'b1);
        // debug halt with and without freeze
        dbg_halt_in   <= 1'b1;
        dbg_freeze_in <= 1'b1;
        rd(WWD_ADDR_CTRL);  q2 = q;
        wait_cyc(40);
        rd(WWD_ADDR_CTRL);  chk(q, q2);
        dbg_freeze_in <= 1'b0;
        wait_cyc(40);
        rd(WWD_ADDR_CTRL);  chk({15'h0, q !== q2}, 16'h0001);
        // clock enable off, then module reset
        dbg_halt_in <= 1'b0;
        clk_en_in   <= 1'b0;
        rd(WWD_ADDR_CTRL);  q2 = q;
        wait_cyc(40);
        rd(WWD_ADDR_CTRL);  chk(q, q2);
        mod_rst_in <= 1'b1;
        wait_cyc(1);
        mod_rst_in <= 1'b0;
        rd(WWD_ADDR_CFG);   chk(q, 16'h007f);
        rd(WWD_ADDR_CTRL);  chk(q, 16'h007f);
        final_report();
    end

endmodule // wwd_top_tb_top
`default_nettype wire
